// ### src/irq_pkg.sv
package irq_pkg;
  // ---------------------------------------------------------------
  // sizes and register map
  // ---------------------------------------------------------------
  localparam int NUM_SRC   = 16;   // sources, fixed order 0 = first
  localparam int VEC_W     = 16;   // code address width
  localparam int ADDR_W    = 4;
  localparam int DATA_W    = 8;
  localparam int GLOBAL_EN_BIT = 7;

  localparam logic [ADDR_W-1:0] OFS_BASIC_EN  = 4'h0; // src 0..6 + global
  localparam logic [ADDR_W-1:0] OFS_EXT_EN    = 4'h1; // src 7..14
  localparam logic [ADDR_W-1:0] OFS_EXT2_EN   = 4'h2; // src 15
  localparam logic [ADDR_W-1:0] OFS_PEND_LO   = 4'h3; // pending 0..7
  localparam logic [ADDR_W-1:0] OFS_PEND_HI   = 4'h4; // pending 8..15
  localparam logic [ADDR_W-1:0] OFS_PRIO_LO   = 4'h5; // 1 = high level
  localparam logic [ADDR_W-1:0] OFS_PRIO_HI   = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 4'h7; // level, active
  localparam logic [ADDR_W-1:0] OFS_EVT_STAT  = 4'h8; // sticky events
  localparam logic [ADDR_W-1:0] OFS_EVT_MASK  = 4'h9;

  localparam logic [DATA_W-1:0]  RST_BYTE  = 8'h00;
  localparam logic [NUM_SRC-1:0] RST_VEC   = 16'h0000;
  // sources whose flag clears itself when the core vectors
  localparam logic [NUM_SRC-1:0] AUTO_CLR_MASK = 16'h0005;
  localparam logic [VEC_W-1:0]   VEC_BASE  = 16'h0003;
  localparam int                 VEC_STEP_SHIFT = 3; // 8 bytes apart

  // event status bits
  localparam int EVT_CALL = 0;
  localparam int EVT_RET  = 1;
  localparam int EVT_W    = 2;

  typedef struct packed {
    logic                    call_valid; // long call request
    logic [VEC_W-1:0]        call_addr;
    logic [$clog2(NUM_SRC)-1:0] call_src;
  } call_req_t;

  typedef struct packed {
    logic found;
    logic [$clog2(NUM_SRC)-1:0] idx;
  } pick_t;
endpackage

// ### src/irq_pick.sv
`timescale 1ns/10ps
// lowest-index set bit finder
module irq_pick
  import irq_pkg::*;
(
  input  wire logic [NUM_SRC-1:0] req,
  output pick_t                   pick
);
  always_comb begin
    pick = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        pick.found = 1'b1;
        pick.idx   = 4'(i);
      end
    end
  end
endmodule

// ### src/two_level_interrupt_handler.sv
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/10ps
module two_level_interrupt_handler
  import irq_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                srst,
  input  wire logic [NUM_SRC-1:0]  src_event,
  input  wire logic                instr_done,
  input  wire logic                call_taken,
  input  wire logic                return_from_irq,
  input  wire logic [ADDR_W-1:0]   bus_addr,
  input  wire logic [DATA_W-1:0]   bus_wdata,
  input  wire logic                bus_we,
  input  wire logic                bus_re,
  output logic [DATA_W-1:0]        bus_rdata,
  output call_req_t                long_call,
  output logic                     irq_out
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_CALL = 3'b100
  } state_t;

  state_t               state_reg;
  logic [NUM_SRC-1:0]   pend_reg;
  logic [NUM_SRC-1:0]   en_reg;
  logic [NUM_SRC-1:0]   prio_reg;
  logic                 global_irq_enable;
  logic                 act_lo_reg;
  logic                 act_hi_reg;
  logic [EVT_W-1:0]     evt_stat_reg;
  logic [EVT_W-1:0]     evt_mask_reg;
  logic [3:0]           sel_reg;
  logic [NUM_SRC-1:0]   req_hi;
  logic [NUM_SRC-1:0]   req_lo;
  logic [NUM_SRC-1:0]   sw_set;
  logic [NUM_SRC-1:0]   sw_clr;
  logic [NUM_SRC-1:0]   auto_clr;
  pick_t                pick_hi;
  pick_t                pick_lo;
  logic                 can_hi;
  logic                 can_lo;
  logic                 want;
  logic [3:0]           want_idx;
  logic                 want_hi;
  logic                 sel_hi_reg;

  // ---------------------------------------------------------------
  // request qualification
  // ---------------------------------------------------------------
  // pending and enabled and global
  always_comb begin
    req_hi = pend_reg & en_reg & prio_reg & {NUM_SRC{global_irq_enable}};
    req_lo = pend_reg & en_reg & ~prio_reg & {NUM_SRC{global_irq_enable}};
  end

  irq_pick u_pick_hi (
    .req  (req_hi),
    .pick (pick_hi)
  );

  irq_pick u_pick_lo (
    .req  (req_lo),
    .pick (pick_lo)
  );

  // block same or lower level while active
  always_comb begin
    can_hi   = pick_hi.found && !act_hi_reg;
    can_lo   = pick_lo.found && !act_hi_reg && !act_lo_reg;
    want     = can_hi || can_lo;
    want_hi  = can_hi;
    want_idx = can_hi ? pick_hi.idx : pick_lo.idx;
  end

  // ---------------------------------------------------------------
  // register write decode
  // ---------------------------------------------------------------
  always_comb begin
    sw_set = '0;
    sw_clr = '0;
    if (bus_we && bus_addr == OFS_PEND_LO) begin
      sw_set[7:0] = bus_wdata;
      sw_clr[7:0] = ~bus_wdata;
    end
    if (bus_we && bus_addr == OFS_PEND_HI) begin
      sw_set[15:8] = bus_wdata;
      sw_clr[15:8] = ~bus_wdata;
    end
  end

  // self-clearing flags drop when the call is taken
  always_comb begin
    auto_clr = '0;
    if (state_reg == ST_CALL && call_taken) begin
      auto_clr[sel_reg] = AUTO_CLR_MASK[sel_reg];
    end
  end

  // ---------------------------------------------------------------
  // pending flags
  // ---------------------------------------------------------------
  // events set flags, set beats clear
  always_ff @(posedge clk) begin
    if (srst) begin
      pend_reg <= RST_VEC;
    end else begin
      pend_reg <= (pend_reg & ~sw_clr & ~auto_clr) | src_event | sw_set;
    end
  end

  // ---------------------------------------------------------------
  // enables and priorities
  // ---------------------------------------------------------------
  // enable bits across basic and extended registers
  always_ff @(posedge clk) begin
    if (srst) begin
      en_reg            <= RST_VEC;
      global_irq_enable <= 1'b0;
    end else if (bus_we) begin
      if (bus_addr == OFS_BASIC_EN) begin
        en_reg[6:0]       <= bus_wdata[6:0];
        global_irq_enable <= bus_wdata[GLOBAL_EN_BIT];
      end
      if (bus_addr == OFS_EXT_EN) begin
        en_reg[14:7] <= bus_wdata;
      end
      if (bus_addr == OFS_EXT2_EN) begin
        en_reg[15] <= bus_wdata[0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      prio_reg <= RST_VEC;
    end else if (bus_we && bus_addr == OFS_PRIO_LO) begin
      prio_reg[7:0] <= bus_wdata;
    end else if (bus_we && bus_addr == OFS_PRIO_HI) begin
      prio_reg[15:8] <= bus_wdata;
    end
  end

  // ---------------------------------------------------------------
  // call sequencer
  // ---------------------------------------------------------------
  // wait for instruction end, then call
  // after return a still-set flag re-requests from idle at once
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg  <= ST_IDLE;
      sel_reg    <= 4'h0;
      sel_hi_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (want) begin
            state_reg  <= ST_WAIT;
            sel_reg    <= want_idx;
            sel_hi_reg <= want_hi;
          end
        end
        ST_WAIT: begin
          if (!want) begin
            state_reg <= ST_IDLE;
          end else if (instr_done) begin
            state_reg  <= ST_CALL;
            sel_reg    <= want_idx;
            sel_hi_reg <= want_hi;
          end else begin
            sel_reg    <= want_idx;
            sel_hi_reg <= want_hi;
          end
        end
        ST_CALL: begin
          if (call_taken) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // return pops the active level, high before low
  // active level marks held until return
  always_ff @(posedge clk) begin
    if (srst) begin
      act_lo_reg <= 1'b0;
      act_hi_reg <= 1'b0;
    end else if (state_reg == ST_CALL && call_taken) begin
      if (sel_hi_reg) begin
        act_hi_reg <= 1'b1;
      end else begin
        act_lo_reg <= 1'b1;
      end
    end else if (return_from_irq) begin
      if (act_hi_reg) begin
        act_hi_reg <= 1'b0;
      end else begin
        act_lo_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      long_call <= '0;
    end else begin
      if ((state_reg == ST_WAIT) && want && instr_done) begin
        long_call.call_valid <= 1'b1; // held until the core takes it
        long_call.call_addr <= VEC_BASE +
          (VEC_W'(want_idx) << VEC_STEP_SHIFT);
        long_call.call_src  <= want_idx;
      end else if (state_reg == ST_CALL && call_taken) begin
        long_call.call_valid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // event interrupt
  // ---------------------------------------------------------------
  // sticky bits, write one clears, set wins
  always_ff @(posedge clk) begin
    if (srst) begin
      evt_stat_reg <= '0;
      evt_mask_reg <= '0;
    end else begin
      evt_stat_reg[EVT_CALL] <= (state_reg == ST_CALL && call_taken) ||
        (evt_stat_reg[EVT_CALL] &&
         !(bus_we && bus_addr == OFS_EVT_STAT && bus_wdata[EVT_CALL]));
      evt_stat_reg[EVT_RET] <= return_from_irq ||
        (evt_stat_reg[EVT_RET] &&
         !(bus_we && bus_addr == OFS_EVT_STAT && bus_wdata[EVT_RET]));
      if (bus_we && bus_addr == OFS_EVT_MASK) begin
        evt_mask_reg <= bus_wdata[EVT_W-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(evt_stat_reg & evt_mask_reg);
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      bus_rdata <= RST_BYTE;
    end else if (bus_re) begin
      unique case (bus_addr)
        OFS_BASIC_EN: bus_rdata <= {global_irq_enable, en_reg[6:0]};
        OFS_EXT_EN:   bus_rdata <= en_reg[14:7];
        OFS_EXT2_EN:  bus_rdata <= {7'h00, en_reg[15]};
        OFS_PEND_LO:  bus_rdata <= pend_reg[7:0];
        OFS_PEND_HI:  bus_rdata <= pend_reg[15:8];
        OFS_PRIO_LO:  bus_rdata <= prio_reg[7:0];
        OFS_PRIO_HI:  bus_rdata <= prio_reg[15:8];
        OFS_STATUS:   bus_rdata <= {6'h00, act_hi_reg, act_lo_reg};
        OFS_EVT_STAT: bus_rdata <= {6'h00, evt_stat_reg};
        OFS_EVT_MASK: bus_rdata <= {6'h00, evt_mask_reg};
        default:      bus_rdata <= RST_BYTE;
      endcase
    end else begin
      bus_rdata <= RST_BYTE;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // event sets flag next cycle
  a_event_sets_flag: assert property (@(posedge clk) disable iff (srst)
    src_event[3] |=> pend_reg[3])
    else $error("event did not set flag");

  a_disabled_no_call: assert property (@(posedge clk) disable iff (srst)
    !global_irq_enable && state_reg == ST_IDLE |=> state_reg == ST_IDLE)
    else $error("request while disabled");

  a_call_after_instr: assert property (@(posedge clk) disable iff (srst)
    $rose(long_call.call_valid) |-> $past(instr_done))
    else $error("call before instruction end");

  a_vector_fixed: assert property (@(posedge clk) disable iff (srst)
    long_call.call_valid |-> long_call.call_addr ==
      VEC_BASE + (VEC_W'(long_call.call_src) << VEC_STEP_SHIFT))
    else $error("wrong vector");

  // only a high call while a low routine runs
  a_block_same_lvl: assert property (@(posedge clk) disable iff (srst)
    act_lo_reg && state_reg == ST_CALL |-> sel_hi_reg)
    else $error("same level not blocked");

  // wait state needs a qualified request
  a_req_needs_enable: assert property (@(posedge clk) disable iff (srst)
    state_reg == ST_WAIT |-> $past(global_irq_enable))
    else $error("request without global enable");

  a_sw_set_flag: assert property (@(posedge clk) disable iff (srst)
    bus_we && bus_addr == OFS_PEND_LO && bus_wdata[0] |=> pend_reg[0])
    else $error("software set lost");

  // auto flag cleared after call when no new event
  a_auto_clear: assert property (@(posedge clk) disable iff (srst)
    state_reg == ST_CALL && call_taken && sel_reg == 4'h0 &&
      !src_event[0] && !sw_set[0] |=> !pend_reg[0])
    else $error("auto clear missed");

  a_high_first: assert property (@(posedge clk) disable iff (srst)
    can_hi |-> want_hi)
    else $error("priority order broken");

  c_call: cover property (@(posedge clk) long_call.call_valid && call_taken);
  c_nest: cover property (@(posedge clk) act_lo_reg && act_hi_reg);
  c_reentry: cover property (@(posedge clk)
    return_from_irq ##[1:4] state_reg == ST_WAIT);
endmodule

// ### testbench/core_model.sv
`timescale 1ns/10ps
// core sequencer stand-in: retires instructions, takes long calls
module core_model
  import irq_pkg::*;
(
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic slow,
  input  wire logic ret_cmd,
  input  call_req_t long_call,
  output logic      instr_done,
  output logic      call_taken,
  output logic      return_from_irq
);
  logic [1:0] div_reg;
  logic [1:0] wait_reg;

  // ------------------------------------------------------------
  // instruction pacing and call acceptance
  // ------------------------------------------------------------
  // boundary every cycle or every fourth
  always_ff @(posedge clk) begin
    if (srst) begin
      div_reg    <= 2'h0;
      instr_done <= 1'b0;
    end else begin
      div_reg    <= div_reg + 2'h1;
      instr_done <= !slow || (div_reg == 2'h3);
    end
  end

  // take call promptly or after a stall
  always_ff @(posedge clk) begin
    if (srst || !long_call.call_valid || call_taken) begin
      wait_reg   <= 2'h0;
      call_taken <= 1'b0;
    end else if (wait_reg == (slow ? 2'h3 : 2'h0)) begin
      call_taken <= 1'b1;
    end else begin
      wait_reg   <= wait_reg + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    return_from_irq <= !srst && ret_cmd;
  end
endmodule

// ### testbench/two_level_interrupt_handler_bench.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("BAD %s exp %h got %h", nm, e, g); \
  end \
end
module two_level_interrupt_handler_bench
  import irq_pkg::*;
;
  localparam int SW = $clog2(NUM_SRC);
  localparam int CW = VEC_W + SW;
  logic                clk = 1'b0;
  logic                srst = 1'b1;
  logic [NUM_SRC-1:0]  src_event = '0;
  logic [ADDR_W-1:0]   bus_addr = '0;
  logic [DATA_W-1:0]   bus_wdata = '0;
  logic                bus_we = 1'b0;
  logic                bus_re = 1'b0;
  logic                slow = 1'b0;
  logic                ret_cmd = 1'b0;
  logic [DATA_W-1:0]   bus_rdata;
  call_req_t           long_call;
  logic                irq_out;
  logic                instr_done;
  logic                call_taken;
  logic                return_from_irq;
  logic                re_q = 1'b0;
  logic                valid_q = 1'b0;
  logic                idone_q = 1'b0;
  logic [DATA_W-1:0]   e_rd;
  logic [CW-1:0]       e_call;
  logic [DATA_W-1:0]   exp_rd[$];
  logic [CW-1:0]       exp_call[$];
  int                  fails = 0;
  int                  check_count = 0;
  int                  seed = 32'had62;

  always #5 clk = ~clk;

  two_level_interrupt_handler uut (
    .clk(clk), .srst(srst), .src_event(src_event),
    .instr_done(instr_done), .call_taken(call_taken),
    .return_from_irq(return_from_irq), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_we(bus_we), .bus_re(bus_re),
    .bus_rdata(bus_rdata), .long_call(long_call), .irq_out(irq_out)
  );

  core_model core (
    .clk(clk), .srst(srst), .slow(slow), .ret_cmd(ret_cmd),
    .long_call(long_call), .instr_done(instr_done),
    .call_taken(call_taken), .return_from_irq(return_from_irq)
  );

  // ------------------------------------------------------------
  // bus, event and core helpers
  // ------------------------------------------------------------
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_we    <= 1'b1;
    @(posedge clk);
    bus_we    <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    exp_rd.push_back(e);
    @(posedge clk);
    bus_addr <= a;
    bus_re   <= 1'b1;
    @(posedge clk);
    bus_re   <= 1'b0;
  endtask

  task automatic pulse(input logic [NUM_SRC-1:0] m);
    @(posedge clk);
    src_event <= m;
    @(posedge clk);
    src_event <= '0;
  endtask

  task automatic expect_call(input int k);
    exp_call.push_back({VEC_W'(VEC_BASE + (k << VEC_STEP_SHIFT)), SW'(k)});
  endtask

  task automatic wait_call;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (call_taken !== 1'b1 && n < 80);
    if (n >= 80) begin
      fails++;
      $display("BAD call_taken exp 1 got 0");
    end
  endtask

  task automatic ret;
    @(posedge clk);
    ret_cmd <= 1'b1;
    @(posedge clk);
    ret_cmd <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic set_en(input int k);
    logic [15:0] v;
    v = 16'h1 << k;
    wr(OFS_BASIC_EN, {1'b1, v[6:0]});
    wr(OFS_EXT_EN, v[14:7]);
    wr(OFS_EXT2_EN, {7'h00, v[15]});
  endtask

  task automatic clr_pend;
    wr(OFS_PEND_LO, 8'h00);
    wr(OFS_PEND_HI, 8'h00);
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // result watcher: read data and call requests against notes
  // ------------------------------------------------------------
  always @(posedge clk) begin
    re_q    <= bus_re;
    valid_q <= long_call.call_valid;
    idone_q <= instr_done;
    if (re_q) begin
      e_rd = exp_rd.size() ? exp_rd.pop_front() : 'x;
      `CHK("bus_rdata", e_rd, bus_rdata)
    end
    if (long_call.call_valid && !valid_q) begin
      e_call = exp_call.size() ? exp_call.pop_front() : 'x;
      `CHK("long_call", e_call, {long_call.call_addr, long_call.call_src})
      `CHK("instr_done", 1'b1, idone_q)
    end
  end

  // watchdog against a hung handshake
  initial begin
    repeat (6000) @(posedge clk);
    fails++;
    $display("BAD watchdog exp done got hang");
    report_and_stop;
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    int k;
    logic [15:0] p;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    for (int a = 0; a < 10; a++) rd(ADDR_W'(a), RST_BYTE);
    wr(4'hf, 8'($random(seed)));
    rd(4'hf, 8'h00);
    done("reset");
    for (k = 0; k < NUM_SRC; k++) begin
      slow <= k[0];
      set_en(k);
      expect_call(k);
      pulse(16'h1 << k);
      wait_call;
      p = AUTO_CLR_MASK[k] ? 16'h0 : 16'h1 << k;
      rd(OFS_PEND_LO, p[7:0]);
      rd(OFS_PEND_HI, p[15:8]);
      rd(OFS_STATUS, 8'h01);
      clr_pend;
      ret;
      rd(OFS_STATUS, 8'h00);
    end
    done("vectors");
    slow <= 1'b0;
    wr(OFS_EVT_STAT, 8'h03);
    wr(OFS_EVT_MASK, 8'h01);
    set_en(1);
    wr(OFS_BASIC_EN, 8'h02);
    pulse(16'h0002);
    repeat (12) @(posedge clk);
    rd(OFS_PEND_LO, 8'h02);
    wr(OFS_BASIC_EN, 8'h80);
    repeat (12) @(posedge clk);
    expect_call(1);
    wr(OFS_BASIC_EN, 8'h82);
    wait_call;
    repeat (3) @(posedge clk);
    `CHK("irq_out", 1'b1, irq_out)
    wr(OFS_EVT_STAT, 8'h01);
    repeat (2) @(posedge clk);
    `CHK("irq_out", 1'b0, irq_out)
    clr_pend;
    ret;
    rd(OFS_EVT_STAT, 8'h02);
    `CHK("irq_out", 1'b0, irq_out)
    done("global");
    k = $unsigned($random(seed)) % NUM_SRC;
    if (AUTO_CLR_MASK[k]) k++;
    set_en(k);
    p = 16'h1 << k;
    expect_call(k);
    wr(OFS_PEND_LO, p[7:0]);
    wr(OFS_PEND_HI, p[15:8]);
    wait_call;
    expect_call(k);
    ret;
    wait_call;
    clr_pend;
    ret;
    done("soft");
    wr(OFS_EXT_EN, 8'h00);
    wr(OFS_EXT2_EN, 8'h00);
    wr(OFS_PRIO_LO, 8'h20);
    wr(OFS_BASIC_EN, 8'hb8);
    expect_call(3);
    pulse(16'h0018);
    wait_call;
    rd(OFS_STATUS, 8'h01);
    expect_call(5);
    pulse(16'h0020);
    wait_call;
    rd(OFS_STATUS, 8'h03);
    wr(OFS_PEND_LO, 8'h10);
    ret;
    repeat (12) @(posedge clk);
    rd(OFS_STATUS, 8'h01);
    expect_call(4);
    ret;
    wait_call;
    clr_pend;
    ret;
    done("priority");
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(OFS_BASIC_EN, RST_BYTE);
    rd(OFS_PRIO_LO, RST_BYTE);
    done("second reset");
    report_and_stop;
  end
endmodule
